// ===== goc_pkg.sv
package goc_pkg;

	// Configuration register indices.
	localparam logic [7:0] GOC_IDX_CLOCK_FAN = 8'h24;
	localparam logic [7:0] GOC_IDX_TRISTATE = 8'h25;
	localparam logic [7:0] GOC_IDX_LOCK_LEGACY = 8'h26;

	// Field positions in the clock and fan option register.
	localparam int GOC_B_CPU1_OD = 7;
	localparam int GOC_B_CLK48 = 6;
	localparam int GOC_B_AUX_OD = 5;
	localparam int GOC_B_SYS_PP = 4;
	localparam int GOC_B_CPU0_PP = 3;
	localparam int GOC_B_KEYBOARD_EN = 2;
	localparam int GOC_B_FLASH_EN = 1;

	// Field positions in the tri-state register.
	localparam int GOC_B_SERB_FLT = 5;
	localparam int GOC_B_SERA_FLT = 4;
	localparam int GOC_B_PAR_FLT = 3;
	localparam int GOC_B_FLP_FLT = 0;

	// Field positions in the lock and legacy register.
	localparam int GOC_B_PORT_SEL = 6;
	localparam int GOC_B_LOCK = 5;
	localparam int GOC_B_FLP_LEG = 3;
	localparam int GOC_B_PAR_LEG = 2;
	localparam int GOC_B_SERA_LEG = 1;
	localparam int GOC_B_SERB_LEG = 0;

	// Writable masks and reset values; strap bits are merged separately.
	localparam logic [7:0] GOC_MASK_CLOCK_FAN = 8'hFA;
	localparam logic [7:0] GOC_MASK_TRISTATE = 8'h39;
	localparam logic [7:0] GOC_MASK_LOCK_LEGACY = 8'h6F;
	localparam logic [7:0] GOC_RST_CLOCK_FAN = 8'h40;
	localparam logic [7:0] GOC_RST_TRISTATE = 8'h00;
	localparam logic [7:0] GOC_RST_LOCK_LEGACY = 8'h00;
	// Fill count at the last enabled edge of the strap window (four edges in all).
	localparam logic [1:0] GOC_STRAP_LAST = 2'h3;

	// Legacy entry key and the two possible entry ports.
	localparam logic [7:0] GOC_ENTRY_KEY = 8'h87;
	localparam logic [7:0] GOC_PORT_LOW = 8'h2E;
	localparam logic [7:0] GOC_PORT_HIGH = 8'h4E;

	// Fan output driver modes carried to the fan block.
	typedef struct packed {
		logic cpu_fan_drive_one_od;
		logic auxiliary_fan_drive_od;
		logic system_fan_drive_od;
		logic cpu_fan_drive_zero_od;
	} goc_fan_mode_t;

	// Legacy interrupt selection controls.
	typedef struct packed {
		logic floppy_legacy_irq_off;
		logic parallel_legacy_irq_off;
		logic serial_a_legacy_irq_off;
		logic serial_b_legacy_irq_off;
	} goc_legacy_t;

	// Interface float controls.
	typedef struct packed {
		logic serial_b_float;
		logic serial_a_float;
		logic parallel_float;
		logic floppy_float;
	} goc_float_t;

endpackage : goc_pkg

// ===== goc_regs.sv
// Behaviour
// - Bit 7 selects CPU fan one open-drain.
// - Bit 6 selects 48 MHz input clock.
// - Bit 5 selects auxiliary fan open-drain.
// - Bit 4 selects system fan push-pull.
// - Bit 3 selects CPU fan zero push-pull.
// - Bit 2 read-only keyboard strap enable.
// - Bit 1 strap-loaded writable flash enable, remaps pins.
// - Tri-state register resets zero, floats interfaces.
// - Bit 6 chooses entry port 2E or 4E.
// - Lock bit blocks configuration reads and writes.
// - Floppy legacy selection honours output register bit.
// - Parallel legacy selection honours control register bit.
// - Serial A legacy selection honours handshake bit.
// - Serial B legacy selection honours handshake bit.
// - Reset values with strap bits taken from pins.
module goc_regs
	import goc_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Configuration access from the host-side decoder.
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output logic cfg_hit,
	// Other configuration registers gate on this lock.
	output logic config_write_lock,
	// Power-on strap pins, asynchronous to the clock.
	input wire logic serial_a_tx_strap_pin,
	input wire logic serial_a_terminal_ready_pin,
	input wire logic serial_a_request_send_pin,
	// Fan drivers and clock select.
	output goc_fan_mode_t fan_mode,
	output logic input_clock_rate_sel,
	// Keyboard and flash enables.
	output logic keyboard_ctrl_strap_en,
	output logic serial_flash_en,
	// Pin mux: high selects the flash function on the four shared pins.
	output logic pin2_flash_clock,
	output logic pin19_flash_chip_enable,
	output logic pin58_flash_in,
	output logic pin118_flash_out,
	// Entry port decode.
	output logic [7:0] config_entry_port,
	output logic [7:0] config_entry_key,
	// Floats and legacy interrupt selection.
	output goc_float_t iface_float,
	output goc_legacy_t legacy_ctrl,
	// Legacy interrupt-select bits from the peripherals.
	input wire logic floppy_dor_bit3,
	input wire logic parallel_device_ctrl_reg_bit4,
	input wire logic serial_a_handshake_ctrl_reg_bit3,
	input wire logic serial_b_handshake_ctrl_reg_bit3,
	// Effective legacy interrupt-select bits.
	output logic floppy_irq_sel_eff,
	output logic parallel_irq_sel_eff,
	output logic serial_a_irq_sel_eff,
	output logic serial_b_irq_sel_eff
);

	// Strap synchronisers: three stages each, second and third must agree.
	logic [2:0] strap_s1_ff;
	logic [2:0] strap_s2_ff;
	logic [2:0] strap_s3_ff;
	// Filtered strap level; updates only when stages two and three agree.
	logic [2:0] strap_lvl_ff;
	// Latch window is open until the fourth enabled edge after reset.
	logic strap_open_ff;
	// Register storage.
	logic [7:0] clock_fan_ff;
	logic [7:0] tristate_ff;
	logic [7:0] lock_legacy_ff;
	// Next filtered strap level, computed from the two settled stages.
	logic [2:0] nxt_strap_lvl;
	// Register images with the strap levels merged in; used only while the
	// window is open, so a host write can never race a strap load.
	logic [7:0] strap_merge_cf;
	logic [7:0] strap_merge_ll;
	// Window stays open until the fill counter reaches its last count.
	logic strap_still_open;
	// Counts enabled edges spent inside the strap window.
	logic [1:0] fill_cnt_ff;

	// Synchronise the strap pins.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_ff <= 3'h0;
			strap_s2_ff <= 3'h0;
			strap_s3_ff <= 3'h0;
			strap_lvl_ff <= 3'h0;
		end
		else if (clk_en)
		begin
			strap_s1_ff <= {serial_a_request_send_pin, serial_a_terminal_ready_pin,
				serial_a_tx_strap_pin};
			strap_s2_ff <= strap_s1_ff;
			strap_s3_ff <= strap_s2_ff;
			strap_lvl_ff <= nxt_strap_lvl;
		end
	end

	// Each strap bit follows the pin only when two synchronised stages agree.
	assign nxt_strap_lvl = (strap_s2_ff & strap_s3_ff)
		| (strap_lvl_ff & (strap_s2_ff | strap_s3_ff));

	// Register decode; the lock hides every register, including its own.
	logic lock_on;
	logic acc_ok;
	logic wr_cf;
	logic wr_ts;
	logic wr_ll;
	assign lock_on = lock_legacy_ff[GOC_B_LOCK];
	assign acc_ok = !lock_on;
	assign wr_cf = cfg_wr && acc_ok && (cfg_index == GOC_IDX_CLOCK_FAN);
	assign wr_ts = cfg_wr && acc_ok && (cfg_index == GOC_IDX_TRISTATE);
	assign wr_ll = cfg_wr && acc_ok && (cfg_index == GOC_IDX_LOCK_LEGACY);
	assign cfg_hit = (cfg_index == GOC_IDX_CLOCK_FAN) || (cfg_index == GOC_IDX_TRISTATE)
		|| (cfg_index == GOC_IDX_LOCK_LEGACY);

	// Next values; the keyboard strap bit always keeps its latched value.
	logic [7:0] nxt_clock_fan;
	logic [7:0] nxt_tristate;
	logic [7:0] nxt_lock_legacy;
	assign nxt_clock_fan = wr_cf
		? ((cfg_wdata & GOC_MASK_CLOCK_FAN) | (clock_fan_ff & ~GOC_MASK_CLOCK_FAN))
		: clock_fan_ff;
	assign nxt_tristate = wr_ts ? (cfg_wdata & GOC_MASK_TRISTATE) : tristate_ff;
	assign nxt_lock_legacy = wr_ll ? (cfg_wdata & GOC_MASK_LOCK_LEGACY) : lock_legacy_ff;

	// Register update. The strap window overrides writes to the two strap-bearing
	// registers for its four edges, because the host cannot be issuing cycles
	// while straps settle.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_fan_ff <= GOC_RST_CLOCK_FAN;
			tristate_ff <= GOC_RST_TRISTATE;
			lock_legacy_ff <= GOC_RST_LOCK_LEGACY;
			strap_open_ff <= 1'b1;
		end
		else if (clk_en)
		begin
			tristate_ff <= nxt_tristate;
			if (strap_open_ff)
			begin
				// Catch strap levels at the window's last edge, then hold them.
				clock_fan_ff <= strap_merge_cf;
				lock_legacy_ff <= strap_merge_ll;
				strap_open_ff <= strap_still_open;
			end
			else
			begin
				clock_fan_ff <= nxt_clock_fan;
				lock_legacy_ff <= nxt_lock_legacy;
			end
		end
	end

	// Strap merge; the window stays open until the synchroniser has filled.
	assign strap_merge_cf = {clock_fan_ff[7:3], nxt_strap_lvl[0], nxt_strap_lvl[1], 1'b0};
	assign strap_merge_ll = {1'b0, nxt_strap_lvl[2], lock_legacy_ff[5:0]};
	assign strap_still_open = (fill_cnt_ff != GOC_STRAP_LAST);

	// Count synchroniser fill cycles after reset release.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fill_cnt_ff <= 2'h0;
		else if (clk_en && strap_open_ff)
			fill_cnt_ff <= fill_cnt_ff + 2'h1;
	end

	// Read mux; a locked bank reads zero.
	assign cfg_rdata = !(cfg_rd && acc_ok) ? 8'h00
		: (cfg_index == GOC_IDX_CLOCK_FAN) ? clock_fan_ff
		: (cfg_index == GOC_IDX_TRISTATE) ? tristate_ff
		: (cfg_index == GOC_IDX_LOCK_LEGACY) ? lock_legacy_ff : 8'h00;
	assign config_write_lock = lock_on;

	// Fan driver modes; two fields are inverted so all outputs read 1 = open-drain.
	assign fan_mode.cpu_fan_drive_one_od = clock_fan_ff[GOC_B_CPU1_OD];
	assign fan_mode.auxiliary_fan_drive_od = clock_fan_ff[GOC_B_AUX_OD];
	assign fan_mode.system_fan_drive_od = !clock_fan_ff[GOC_B_SYS_PP];
	assign fan_mode.cpu_fan_drive_zero_od = !clock_fan_ff[GOC_B_CPU0_PP];
	assign input_clock_rate_sel = clock_fan_ff[GOC_B_CLK48];

	// Strap-derived enables and the flash pin remap.
	assign keyboard_ctrl_strap_en = clock_fan_ff[GOC_B_KEYBOARD_EN];
	assign serial_flash_en = clock_fan_ff[GOC_B_FLASH_EN];
	assign pin2_flash_clock = serial_flash_en;
	assign pin19_flash_chip_enable = serial_flash_en;
	assign pin58_flash_in = serial_flash_en;
	assign pin118_flash_out = serial_flash_en;

	// Entry port selection.
	assign config_entry_port = lock_legacy_ff[GOC_B_PORT_SEL] ? GOC_PORT_HIGH
		: GOC_PORT_LOW;
	assign config_entry_key = GOC_ENTRY_KEY;

	// Interface floats.
	assign iface_float.serial_b_float = tristate_ff[GOC_B_SERB_FLT];
	assign iface_float.serial_a_float = tristate_ff[GOC_B_SERA_FLT];
	assign iface_float.parallel_float = tristate_ff[GOC_B_PAR_FLT];
	assign iface_float.floppy_float = tristate_ff[GOC_B_FLP_FLT];

	// Legacy interrupt selection: a set control masks the peripheral bit.
	assign legacy_ctrl.floppy_legacy_irq_off = lock_legacy_ff[GOC_B_FLP_LEG];
	assign legacy_ctrl.parallel_legacy_irq_off = lock_legacy_ff[GOC_B_PAR_LEG];
	assign legacy_ctrl.serial_a_legacy_irq_off = lock_legacy_ff[GOC_B_SERA_LEG];
	assign legacy_ctrl.serial_b_legacy_irq_off = lock_legacy_ff[GOC_B_SERB_LEG];
	assign floppy_irq_sel_eff = floppy_dor_bit3 && !legacy_ctrl.floppy_legacy_irq_off;
	assign parallel_irq_sel_eff = parallel_device_ctrl_reg_bit4
		&& !legacy_ctrl.parallel_legacy_irq_off;
	assign serial_a_irq_sel_eff = serial_a_handshake_ctrl_reg_bit3
		&& !legacy_ctrl.serial_a_legacy_irq_off;
	assign serial_b_irq_sel_eff = serial_b_handshake_ctrl_reg_bit3
		&& !legacy_ctrl.serial_b_legacy_irq_off;

	// Last enabled edge of the strap window, with both filter stages agreeing,
	// so the level loaded there is the settled pin level.
	sequence strap_close_s;
		clk_en && strap_open_ff && (fill_cnt_ff == GOC_STRAP_LAST)
			&& (strap_s2_ff == strap_s3_ff);
	endsequence
	// One edge later every strap-bearing bit shows that level and the window is shut.
	sequence strap_taken_s;
		!strap_open_ff
			&& (keyboard_ctrl_strap_en == $past(strap_s3_ff[0]))
			&& (serial_flash_en == $past(strap_s3_ff[1]))
			&& (lock_legacy_ff[GOC_B_PORT_SEL] == $past(strap_s3_ff[2]));
	endsequence
	// An enabled edge after the window, when only host writes may change the bank.
	sequence host_edge_s;
		clk_en && !strap_open_ff;
	endsequence

	// Straps are caught at the close of the window and shown one edge later.
	strap_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
		strap_close_s |=> strap_taken_s)
		else $error("strap level not latched");
	// Locked bank ignores writes to the clock and fan register.
	lock_blocks_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && lock_on && !strap_open_ff) |=> $stable(clock_fan_ff))
		else $error("locked register changed");
	// The lock cannot clear itself; only reset lifts it.
	lock_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && lock_on) |=> lock_on)
		else $error("lock bit cleared");
	// Keyboard strap bit never follows a write.
	keyboard_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
		host_edge_s |=> $stable(clock_fan_ff[GOC_B_KEYBOARD_EN]))
		else $error("keyboard strap bit changed");
	// Flash bit follows an unlocked write, so software may override the strap.
	flash_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && wr_cf && !strap_open_ff)
		|=> serial_flash_en == $past(cfg_wdata[GOC_B_FLASH_EN]))
		else $error("flash enable not written");
	// Tri-state write lands with its reserved bits dropped.
	tristate_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && wr_ts) |=> tristate_ff == ($past(cfg_wdata) & GOC_MASK_TRISTATE))
		else $error("tri-state write lost");
	// A low clock enable holds every register and the strap window.
	clock_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> $stable(clock_fan_ff) && $stable(tristate_ff) && $stable(lock_legacy_ff)
			&& $stable(strap_open_ff))
		else $error("state moved while disabled");
	// Port choice follows its bit.
	entry_port_a: assert property (@(posedge clock) disable iff (!rst_n)
		config_entry_port == (lock_legacy_ff[GOC_B_PORT_SEL] ? GOC_PORT_HIGH : GOC_PORT_LOW))
		else $error("entry port wrong");
	// System fan and cpu zero are inverted relative to their bits.
	fan_polarity_a: assert property (@(posedge clock) disable iff (!rst_n)
		fan_mode.system_fan_drive_od != clock_fan_ff[GOC_B_SYS_PP]
		&& fan_mode.cpu_fan_drive_zero_od != clock_fan_ff[GOC_B_CPU0_PP])
		else $error("fan polarity wrong");
	// Locked reads return zero.
	lock_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		lock_on |-> cfg_rdata == 8'h00)
		else $error("locked read leaked");
	// Legacy masking of the floppy select bit.
	floppy_legacy_a: assert property (@(posedge clock) disable iff (!rst_n)
		legacy_ctrl.floppy_legacy_irq_off |-> !floppy_irq_sel_eff)
		else $error("floppy legacy bit not ignored");
	// Legacy masking of the parallel select bit.
	parallel_legacy_a: assert property (@(posedge clock) disable iff (!rst_n)
		legacy_ctrl.parallel_legacy_irq_off |-> !parallel_irq_sel_eff)
		else $error("parallel legacy bit not ignored");
	// Legacy masking of the serial A select bit.
	serial_a_legacy_a: assert property (@(posedge clock) disable iff (!rst_n)
		legacy_ctrl.serial_a_legacy_irq_off |-> !serial_a_irq_sel_eff)
		else $error("serial A legacy bit not ignored");
	// Legacy masking of the serial B select bit.
	serial_b_legacy_a: assert property (@(posedge clock) disable iff (!rst_n)
		legacy_ctrl.serial_b_legacy_irq_off |-> !serial_b_irq_sel_eff)
		else $error("serial B legacy bit not ignored");

endmodule // goc_regs

// ===== goc_host.sv
// Host side of the configuration path: issues one-byte index accesses.
module goc_host
	import goc_pkg::*;
(
	// Clock and answers from the register bank.
	input wire logic clock,
	input wire logic [7:0] cfg_rdata,
	input wire logic [7:0] config_entry_port,
	// Access request.
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_index,
	output logic [7:0] cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero with both strobes low.
	initial
	begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_index = 8'hFF;
		cfg_wdata = 8'h00;
	end

	// A write stands one full cycle; released lines show inverted data,
	// so stale values never match.
	task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
		@(negedge clock);
		cfg_index = idx;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clock);
		cfg_wr = 1'b0;
		cfg_index = ~idx;
		cfg_wdata = ~d;
	endtask

	// Read data is taken at the rising edge that the request spans.
	task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
		@(negedge clock);
		cfg_index = idx;
		cfg_rd = 1'b1;
		@(posedge clock);
		d = cfg_rdata;
		@(negedge clock);
		cfg_rd = 1'b0;
		cfg_index = ~idx;
	endtask

	// Entry sequence: the key twice to whichever port the bank selects.
	task automatic enter_config();
		write_reg(config_entry_port, GOC_ENTRY_KEY);
		write_reg(config_entry_port, GOC_ENTRY_KEY);
	endtask
endmodule // goc_host

// ===== tb_global_option_config_regs.sv
// Self-checking bench for the global option registers.
module tb_global_option_config_regs;
	import goc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// One table row: access, expected read-back and expected output summary.
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [15:0] obs;
	} goc_row_t;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic cfg_wr, cfg_rd, cfg_hit, config_write_lock, input_clock_rate_sel;
	logic [7:0] cfg_index, cfg_wdata, cfg_rdata, config_entry_port, config_entry_key, rd;
	logic [2:0] strap = 3'b111;
	logic [3:0] periph = 4'hF;
	logic [3:0] eff;
	logic keyboard_ctrl_strap_en, serial_flash_en, p2, p19, p58, p118;
	goc_fan_mode_t fan_mode;
	goc_float_t iface_float;
	goc_legacy_t legacy_ctrl;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Decoder hit flag as seen at the edge that takes the latest read.
	logic hit_seen;
	goc_row_t rows [7];
	// Summary of the decoded outputs, compared as one vector per row.
	wire [15:0] obs = {fan_mode, input_clock_rate_sel, serial_flash_en, iface_float,
		legacy_ctrl, config_entry_port == GOC_PORT_HIGH, config_write_lock};

	always #25 clock = ~clock;

	goc_regs goc_regs_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .config_write_lock(config_write_lock),
		.serial_a_tx_strap_pin(strap[2]), .serial_a_terminal_ready_pin(strap[1]),
		.serial_a_request_send_pin(strap[0]), .fan_mode(fan_mode),
		.input_clock_rate_sel(input_clock_rate_sel),
		.keyboard_ctrl_strap_en(keyboard_ctrl_strap_en), .serial_flash_en(serial_flash_en),
		.pin2_flash_clock(p2), .pin19_flash_chip_enable(p19), .pin58_flash_in(p58),
		.pin118_flash_out(p118), .config_entry_port(config_entry_port),
		.config_entry_key(config_entry_key), .iface_float(iface_float),
		.legacy_ctrl(legacy_ctrl), .floppy_dor_bit3(periph[3]),
		.parallel_device_ctrl_reg_bit4(periph[2]), .serial_a_handshake_ctrl_reg_bit3(periph[1]),
		.serial_b_handshake_ctrl_reg_bit3(periph[0]), .floppy_irq_sel_eff(eff[3]),
		.parallel_irq_sel_eff(eff[2]), .serial_a_irq_sel_eff(eff[1]),
		.serial_b_irq_sel_eff(eff[0]));

	goc_host goc_host_inst (.clock(clock), .cfg_rdata(cfg_rdata),
		.config_entry_port(config_entry_port), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_index(cfg_index), .cfg_wdata(cfg_wdata));

	// Compare one value and count it.
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// The only place the run ends.
	task automatic print_verdict();
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Reset for ten cycles with the given straps, then wait out the strap window.
	task automatic do_reset(input logic [2:0] s);
		@(negedge clock);
		rst_n = 1'b0;
		strap = s;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask

	// Hang guard: the whole run needs well under a thousand cycles.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			print_verdict();
		end
	end

	// Capture the hit flag while the read request stands.
	always @(posedge clock)
	begin
		if (cfg_rd)
			hit_seen <= cfg_hit;
	end

	initial
	begin
		// Summary: fan od x4, 48 MHz, flash, floats x4, legacy-off x4, high port, lock.
		rows = '{'{8'h24, 8'hFF, 8'hFE, 16'hCC02}, '{8'h24, 8'h00, 8'h04, 16'h3002},
			'{8'h25, 8'hFF, 8'h39, 16'h33C2}, '{8'h26, 8'h1F, 8'h0F, 16'h33FC},
			'{8'h27, 8'hFF, 8'h00, 16'h33FC}, '{8'h25, 8'h00, 8'h00, 16'h303C},
			'{8'h26, 8'h40, 8'h40, 16'h3002}};
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		repeat (8) @(negedge clock);
		// Reset values with all straps high.
		goc_host_inst.read_reg(8'h24, rd);
		check({8'h00, rd}, 16'h0046, "24h reset");
		goc_host_inst.read_reg(8'h25, rd);
		check({8'h00, rd}, 16'h0000, "25h reset");
		goc_host_inst.read_reg(8'h26, rd);
		check({8'h00, rd}, 16'h0040, "26h reset");
		check({11'h000, p2, p19, p58, p118, keyboard_ctrl_strap_en}, 16'h001F,
			"strap outs");
		check(obs, 16'h3C02, "reset outputs");
		check({8'h00, config_entry_key}, {8'h00, GOC_ENTRY_KEY}, "entry key");
		goc_host_inst.enter_config();
		// Table of writes, read-back and decoded outputs.
		foreach (rows[i])
		begin
			goc_host_inst.write_reg(rows[i].idx, rows[i].wd);
			goc_host_inst.read_reg(rows[i].idx, rd);
			check({8'h00, rd}, {8'h00, rows[i].rd}, "row read");
			check({15'h0000, hit_seen}, {15'h0000, rows[i].idx != 8'h27}, "row hit");
			check(obs, rows[i].obs, "row outputs");
		end
		// Legacy bits pass through, then are ignored once the legacy-off bits are set.
		check({12'h000, eff}, 16'h000F, "legacy on");
		goc_host_inst.write_reg(8'h26, 8'h0F);
		check({12'h000, eff}, 16'h0000, "legacy off");
		// Disabled clock freezes the bank.
		clk_en = 1'b0;
		goc_host_inst.write_reg(8'h25, 8'h01);
		clk_en = 1'b1;
		check({12'h000, iface_float}, 16'h0000, "frozen write");
		// Lock blocks writes and reads, including reads of itself.
		goc_host_inst.write_reg(8'h26, 8'h20);
		goc_host_inst.write_reg(8'h25, 8'h3F);
		goc_host_inst.read_reg(8'h26, rd);
		check({7'h00, config_write_lock, rd}, 16'h0100, "locked");
		check({12'h000, iface_float}, 16'h0000, "locked write");
		// Second reset with straps low; later strap changes are not seen.
		do_reset(3'b000);
		strap = 3'b111;
		repeat (4) @(negedge clock);
		goc_host_inst.read_reg(8'h24, rd);
		check({8'h00, rd}, 16'h0040, "24h low straps");
		goc_host_inst.read_reg(8'h26, rd);
		check({8'h00, rd}, 16'h0000, "26h low straps");
		check({8'h00, config_entry_port}, {8'h00, GOC_PORT_LOW}, "low port");
		check({11'h000, p2, p19, p58, p118, keyboard_ctrl_strap_en}, 16'h0000,
			"low strap outs");
		print_verdict();
	end
endmodule // tb_global_option_config_regs
